// [mscr_init_pulse.sv]
`timescale 1ns/10ps
// Stretches a one-cycle start into an init level of fixed length
module mscr_init_pulse
(
	input  wire logic aclk,
	input  wire logic aresetn,
	input  wire logic start,
	output logic      init
);

	mscr_pkg::mscr_pulse_state_s st_reg;
	mscr_pkg::mscr_pulse_state_s st_next;

	// ==========================================================
	// Countdown; a new start restarts the count, so none is lost
	always_comb
	begin
		st_next = st_reg;
		if (start)
		begin
			st_next.busy = 1'b1;
			st_next.cnt  = 8'(mscr_pkg::INIT_CYCLES - 1);
		end
		else if (st_reg.busy)
		begin
			if (st_reg.cnt == 8'h00)
				st_next.busy = 1'b0;
			else
				st_next.cnt = st_reg.cnt - 8'h01;
		end
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			st_reg <= '0;
		else
			st_reg <= st_next;
	end

	assign init = st_reg.busy;

endmodule

// [mscr_pkg.sv]
package mscr_pkg;

	// ==========================================================
	// Bus geometry
	localparam int ADDR_W = 16;
	localparam int DATA_W = 32;

	// ==========================================================
	// Register indices; byte address is four times the index
	localparam logic [15:0] IDX_RESET   = 16'h2190;
	localparam logic [15:0] IDX_MACCTL  = 16'h2191;
	localparam logic [15:0] IDX_SEQ     = 16'h2192;
	localparam logic [15:0] IDX_SECCTL  = 16'h2193;
	localparam logic [15:0] IDX_TXLEN   = 16'h2194;
	localparam logic [15:0] IDX_RXLEN   = 16'h2195;
	localparam logic [15:0] IDX_MAP     = 16'h219F;

	// ==========================================================
	// Reset register fields
	localparam int RST_FIFO_BIT = 7;
	localparam int RST_TX_BIT   = 6;
	localparam int RST_RX_BIT   = 5;
	localparam int RST_AES_BIT  = 4;
	localparam int RST_LSB      = 4;
	localparam int UNIT_COUNT   = 4;

	// ==========================================================
	// MAC control fields and write masks
	localparam int ACK_FILT_BIT = 4;
	localparam int COORD_BIT    = 3;
	localparam int ADDR_FILT_BIT = 2;
	localparam int CRC_FILT_BIT = 1;
	localparam logic [7:0] MACCTL_MASK = 8'h1E;
	localparam logic [7:0] LEN_MASK    = 8'h7F;
	localparam logic [7:0] MAP_MASK    = 8'h01;

	// ==========================================================
	// Security control fields
	localparam int SA_KEY_BIT  = 7;
	localparam int TX_KEY_BIT  = 6;
	localparam int RX_KEY_BIT  = 5;
	localparam int TAG_MSB     = 4;
	localparam int TAG_LSB     = 2;
	localparam int BANK_BIT    = 0;
	localparam logic [4:0] TAG_MIN  = 5'h04;
	localparam logic [4:0] TAG_MAX  = 5'h10;
	localparam logic [2:0] TAG_TOP  = 3'h6;

	// ==========================================================
	// Reset values and timing
	localparam logic [7:0] REG_RESET_VAL = 8'h00;
	localparam int INIT_NS     = 40;
	localparam int CLK_NS      = 10;
	localparam int INIT_CYCLES = (INIT_NS + CLK_NS - 1) / CLK_NS;
	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	// ==========================================================
	// Types
	typedef enum logic [1:0] {
		MODE_NONE = 2'b00,
		MODE_CBC  = 2'b01,
		MODE_CTR  = 2'b10,
		MODE_CCM  = 2'b11
	} mscr_mode_e;

	typedef enum logic [2:0] {
		REG_RESET  = 3'b000,
		REG_MACCTL = 3'b001,
		REG_SEQ    = 3'b010,
		REG_SECCTL = 3'b011,
		REG_TXLEN  = 3'b100,
		REG_RXLEN  = 3'b101,
		REG_MAP    = 3'b110,
		REG_NONE   = 3'b111
	} mscr_reg_e;

	typedef struct packed {
		logic       cipher_en;
		logic       auth_en;
		logic [6:0] cipher_offset;
		logic [6:0] auth_offset;
		logic [6:0] auth_only_len;
		logic [4:0] tag_bytes;
	} mscr_aes_plan_s;

	typedef struct packed {
		logic       done;
		logic       is_ack;
		logic [7:0] dsn;
		logic       addr_match;
		logic       crc_ok;
	} mscr_rx_frame_s;

	typedef struct packed {
		logic       busy;
		logic [7:0] cnt;
	} mscr_pulse_state_s;

	typedef struct packed {
		logic irq;
		logic drop;
	} mscr_filter_state_s;

	typedef struct packed {
		logic           awready;
		logic           wready;
		logic           aw_have;
		logic           w_have;
		logic [15:0]    awaddr;
		logic [7:0]     wbyte;
		logic           wlane;
		logic           bvalid;
		logic [1:0]     bresp;
		logic           arready;
		logic           rvalid;
		logic [31:0]    rdata;
		logic [1:0]     rresp;
		logic [7:0]     mac_control;
		logic [7:0]     expected_sequence_number;
		logic [7:0]     security_control;
		logic [7:0]     transmit_cipher_length;
		logic [7:0]     receive_cipher_length;
		logic [7:0]     map_select;
		logic [3:0]     init_start;
		mscr_aes_plan_s tx_plan;
		mscr_aes_plan_s rx_plan;
		logic [127:0]   standalone_key;
		logic [127:0]   tx_key;
		logic [127:0]   rx_key;
	} mscr_regs_state_s;

endpackage

// [mscr_regs.sv]
`timescale 1ns/10ps
// Contract
// - Reset bit 7 initializes the packet FIFO
// - Reset bit 6 initializes transmit state machine
// - Reset bit 5 initializes receive state machine
// - Reset bit 4 reinitializes the AES engine
// - Ack check drops interrupt on sequence mismatch
// - Control bit 3 enables coordinator role
// - Address filter drops interrupt on address mismatch
// - Auto CRC drops interrupt on bad CRC
// - Eight-bit expected sequence register, read-write
// - Security bit 7 picks standalone key
// - Security bit 6 picks transmit key
// - Security bit 5 picks receive key
// - Bits 4:2 pick tag length 4..16
// - Seven-bit transmit length, bit 7 zero
// - Seven-bit receive length, same meaning
// - Counter mode: length skips to cipher start
// - CCM: length counts authenticate-only bytes
// - Map bit 0 selects MAC or security bank
// - Keys are 16 bytes, top byte highest
// - FIFOs 256 bytes, banks share one range
module mscr_regs
(
	input  wire logic                     aclk,
	input  wire logic                     aresetn,
	// AXI4-Lite slave
	input  wire logic [15:0]              s_axi_awaddr,
	input  wire logic                     s_axi_awvalid,
	output logic                          s_axi_awready,
	input  wire logic [31:0]              s_axi_wdata,
	input  wire logic [3:0]               s_axi_wstrb,
	input  wire logic                     s_axi_wvalid,
	output logic                          s_axi_wready,
	output logic [1:0]                    s_axi_bresp,
	output logic                          s_axi_bvalid,
	input  wire logic                     s_axi_bready,
	input  wire logic [15:0]              s_axi_araddr,
	input  wire logic                     s_axi_arvalid,
	output logic                          s_axi_arready,
	output logic [31:0]                   s_axi_rdata,
	output logic [1:0]                    s_axi_rresp,
	output logic                          s_axi_rvalid,
	input  wire logic                     s_axi_rready,
	// Key store contents
	input  wire logic [127:0]             first_key,
	input  wire logic [127:0]             second_key,
	// Received frame summary from the receive path
	input  wire mscr_pkg::mscr_rx_frame_s rx_frame,
	// Unit controls
	output logic                          fifo_init,
	output logic                          tx_fsm_init,
	output logic                          rx_fsm_init,
	output logic                          aes_init,
	output logic                          coordinator_role,
	output logic                          bank_select,
	output logic                          standalone_key_select,
	output logic                          transmit_key_select,
	output logic                          receive_key_select,
	output logic [127:0]                  standalone_key,
	output logic [127:0]                  transmit_key,
	output logic [127:0]                  receive_key,
	output mscr_pkg::mscr_aes_plan_s      tx_plan,
	output mscr_pkg::mscr_aes_plan_s      rx_plan,
	output logic                          rx_irq,
	output logic                          rx_drop
);

	mscr_pkg::mscr_regs_state_s st_reg;
	mscr_pkg::mscr_regs_state_s st_next;
	logic [3:0]                 unit_busy;

	// ==========================================================
	// Address decode, shared by read and write paths
	function automatic mscr_pkg::mscr_reg_e decode
	(
		input logic [15:0] addr
	);
		mscr_pkg::mscr_reg_e r;
		r = mscr_pkg::REG_NONE;
		if (addr[15:2] == mscr_pkg::IDX_RESET[13:0])
			r = mscr_pkg::REG_RESET;
		else if (addr[15:2] == mscr_pkg::IDX_MACCTL[13:0])
			r = mscr_pkg::REG_MACCTL;
		else if (addr[15:2] == mscr_pkg::IDX_SEQ[13:0])
			r = mscr_pkg::REG_SEQ;
		else if (addr[15:2] == mscr_pkg::IDX_SECCTL[13:0])
			r = mscr_pkg::REG_SECCTL;
		else if (addr[15:2] == mscr_pkg::IDX_TXLEN[13:0])
			r = mscr_pkg::REG_TXLEN;
		else if (addr[15:2] == mscr_pkg::IDX_RXLEN[13:0])
			r = mscr_pkg::REG_RXLEN;
		else if (addr[15:2] == mscr_pkg::IDX_MAP[13:0])
			r = mscr_pkg::REG_MAP;
		return r;
	endfunction

	// ==========================================================
	// Tag length: even counts from four; top code saturates
	function automatic logic [4:0] tag_len
	(
		input logic [2:0] code
	);
		logic [4:0] t;
		if (code > mscr_pkg::TAG_TOP)
			t = mscr_pkg::TAG_MAX;
		else
			t = mscr_pkg::TAG_MIN + {1'b0, code, 1'b0};
		return t;
	endfunction

	// ==========================================================
	// Turns mode and length into offsets for the AES engine
	function automatic mscr_pkg::mscr_aes_plan_s aes_plan
	(
		input logic [7:0] sec,
		input logic [7:0] len
	);
		mscr_pkg::mscr_aes_plan_s p;
		mscr_pkg::mscr_mode_e     mode;
		p    = '0;
		mode = mscr_pkg::mscr_mode_e'(sec[1:0]);
		case (mode)
			mscr_pkg::MODE_CTR:
			begin
				p.cipher_en     = 1'b1;
				p.cipher_offset = len[6:0];
			end
			mscr_pkg::MODE_CBC:
			begin
				p.auth_en     = 1'b1;
				p.auth_offset = len[6:0];
			end
			mscr_pkg::MODE_CCM:
			begin
				p.cipher_en     = 1'b1;
				p.auth_en       = 1'b1;
				p.auth_only_len = len[6:0];
				p.cipher_offset = len[6:0];
			end
			default:
			begin
				p = '0;
			end
		endcase
		// A tag only exists where something is authenticated
		if (p.auth_en)
			p.tag_bytes = tag_len(sec[mscr_pkg::TAG_MSB:mscr_pkg::TAG_LSB]);
		return p;
	endfunction

	// ==========================================================
	// Read mux; reserved bits and unmapped space return zero
	function automatic logic [7:0] read_byte
	(
		input mscr_pkg::mscr_regs_state_s s,
		input logic [3:0]                 busy,
		input mscr_pkg::mscr_reg_e        r
	);
		logic [7:0] v;
		v = 8'h00;
		case (r)
			mscr_pkg::REG_RESET:  v = {busy, 4'h0};
			mscr_pkg::REG_MACCTL: v = s.mac_control;
			mscr_pkg::REG_SEQ:    v = s.expected_sequence_number;
			mscr_pkg::REG_SECCTL: v = s.security_control;
			mscr_pkg::REG_TXLEN:  v = s.transmit_cipher_length;
			mscr_pkg::REG_RXLEN:  v = s.receive_cipher_length;
			mscr_pkg::REG_MAP:    v = s.map_select;
			default:              v = 8'h00;
		endcase
		return v;
	endfunction

	// ==========================================================
	// Bus handshakes, register writes and derived controls
	always_comb
	begin
		mscr_pkg::mscr_reg_e wr_sel;
		mscr_pkg::mscr_reg_e rd_sel;
		st_next            = st_reg;
		st_next.init_start = 4'h0;
		wr_sel             = decode(st_reg.awaddr);
		rd_sel             = decode(s_axi_araddr);

		// Address and data are captured in either order
		if (s_axi_awvalid && st_reg.awready)
		begin
			st_next.aw_have = 1'b1;
			st_next.awaddr  = s_axi_awaddr;
		end
		if (s_axi_wvalid && st_reg.wready)
		begin
			st_next.w_have = 1'b1;
			st_next.wbyte  = s_axi_wdata[7:0];
			st_next.wlane  = s_axi_wstrb[0];
		end

		// Commit once both halves are held; lane 0 gates the store
		if (st_reg.aw_have && st_reg.w_have && !st_reg.bvalid)
		begin
			st_next.aw_have = 1'b0;
			st_next.w_have  = 1'b0;
			st_next.bvalid  = 1'b1;
			st_next.bresp   = (wr_sel == mscr_pkg::REG_NONE) ?
				mscr_pkg::RESP_SLVERR : mscr_pkg::RESP_OKAY;
			if (st_reg.wlane)
			begin
				case (wr_sel)
					mscr_pkg::REG_RESET:
					begin
						// Ones start units; zeros and low bits do nothing
						st_next.init_start =
							st_reg.wbyte[7:mscr_pkg::RST_LSB];
					end
					mscr_pkg::REG_MACCTL:
					begin
						st_next.mac_control =
							st_reg.wbyte & mscr_pkg::MACCTL_MASK;
					end
					mscr_pkg::REG_SEQ:
					begin
						st_next.expected_sequence_number = st_reg.wbyte;
					end
					mscr_pkg::REG_SECCTL:
					begin
						st_next.security_control = st_reg.wbyte;
					end
					mscr_pkg::REG_TXLEN:
					begin
						st_next.transmit_cipher_length =
							st_reg.wbyte & mscr_pkg::LEN_MASK;
					end
					mscr_pkg::REG_RXLEN:
					begin
						st_next.receive_cipher_length =
							st_reg.wbyte & mscr_pkg::LEN_MASK;
					end
					mscr_pkg::REG_MAP:
					begin
						st_next.map_select =
							st_reg.wbyte & mscr_pkg::MAP_MASK;
					end
					default:
					begin
						st_next.map_select = st_reg.map_select;
					end
				endcase
			end
		end
		if (st_reg.bvalid && s_axi_bready)
			st_next.bvalid = 1'b0;
		// Hold off new halves until the response has gone
		st_next.awready = !st_next.aw_have && !st_next.bvalid;
		st_next.wready  = !st_next.w_have && !st_next.bvalid;

		// Reads answer one cycle after the address is taken
		if (st_reg.rvalid && s_axi_rready)
			st_next.rvalid = 1'b0;
		if (s_axi_arvalid && st_reg.arready)
		begin
			st_next.rvalid = 1'b1;
			st_next.rdata  = {24'h000000,
				read_byte(st_reg, unit_busy, rd_sel)};
			st_next.rresp  = (rd_sel == mscr_pkg::REG_NONE) ?
				mscr_pkg::RESP_SLVERR : mscr_pkg::RESP_OKAY;
		end
		st_next.arready = !st_next.rvalid;

		// AES plans follow the stored mode and lengths
		st_next.tx_plan = aes_plan(st_reg.security_control,
			st_reg.transmit_cipher_length);
		st_next.rx_plan = aes_plan(st_reg.security_control,
			st_reg.receive_cipher_length);

		// Key routing; byte 15 (bits 127:120) is the top byte
		st_next.standalone_key =
			st_reg.security_control[mscr_pkg::SA_KEY_BIT] ?
			second_key : first_key;
		st_next.tx_key =
			st_reg.security_control[mscr_pkg::TX_KEY_BIT] ?
			second_key : first_key;
		st_next.rx_key =
			st_reg.security_control[mscr_pkg::RX_KEY_BIT] ?
			second_key : first_key;
	end

	// ==========================================================
	// State register
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			st_reg                          <= '0;
			st_reg.mac_control              <= mscr_pkg::REG_RESET_VAL;
			st_reg.expected_sequence_number <= mscr_pkg::REG_RESET_VAL;
			st_reg.security_control         <= mscr_pkg::REG_RESET_VAL;
			st_reg.transmit_cipher_length   <= mscr_pkg::REG_RESET_VAL;
			st_reg.receive_cipher_length    <= mscr_pkg::REG_RESET_VAL;
			st_reg.map_select               <= mscr_pkg::REG_RESET_VAL;
		end
		else
			st_reg <= st_next;
	end

	// ==========================================================
	// Init stretchers, one per unit; bit reads one while busy
	genvar gi;
	generate
		for (gi = 0; gi < mscr_pkg::UNIT_COUNT; gi++)
		begin : g_unit
			mscr_init_pulse u_pulse
			(
				.aclk    (aclk),
				.aresetn (aresetn),
				.start   (st_reg.init_start[gi]),
				.init    (unit_busy[gi])
			);
		end
	endgenerate

	// ==========================================================
	// Receive interrupt filtering
	mscr_rx_filter u_filter
	(
		.aclk                     (aclk),
		.aresetn                  (aresetn),
		.hold                     (unit_busy[mscr_pkg::RST_RX_BIT -
		                                     mscr_pkg::RST_LSB]),
		.frame                    (rx_frame),
		.ack_sequence_filter      (st_reg.mac_control[
		                                     mscr_pkg::ACK_FILT_BIT]),
		.addr_filter              (st_reg.mac_control[
		                                     mscr_pkg::ADDR_FILT_BIT]),
		.crc_filter               (st_reg.mac_control[
		                                     mscr_pkg::CRC_FILT_BIT]),
		.expected_sequence_number (st_reg.expected_sequence_number),
		.rx_irq                   (rx_irq),
		.rx_drop                  (rx_drop)
	);

	// ==========================================================
	// Outputs, all from flip-flops
	assign s_axi_awready = st_reg.awready;
	assign s_axi_wready  = st_reg.wready;
	assign s_axi_bvalid  = st_reg.bvalid;
	assign s_axi_bresp   = st_reg.bresp;
	assign s_axi_arready = st_reg.arready;
	assign s_axi_rvalid  = st_reg.rvalid;
	assign s_axi_rdata   = st_reg.rdata;
	assign s_axi_rresp   = st_reg.rresp;

	// Unit init levels straight from the stretchers
	assign fifo_init   = unit_busy[mscr_pkg::RST_FIFO_BIT -
		mscr_pkg::RST_LSB];
	assign tx_fsm_init = unit_busy[mscr_pkg::RST_TX_BIT -
		mscr_pkg::RST_LSB];
	assign rx_fsm_init = unit_busy[mscr_pkg::RST_RX_BIT -
		mscr_pkg::RST_LSB];
	assign aes_init    = unit_busy[mscr_pkg::RST_AES_BIT -
		mscr_pkg::RST_LSB];

	// Static controls
	assign coordinator_role =
		st_reg.mac_control[mscr_pkg::COORD_BIT];
	assign bank_select =
		st_reg.map_select[mscr_pkg::BANK_BIT];
	assign standalone_key_select =
		st_reg.security_control[mscr_pkg::SA_KEY_BIT];
	assign transmit_key_select =
		st_reg.security_control[mscr_pkg::TX_KEY_BIT];
	assign receive_key_select =
		st_reg.security_control[mscr_pkg::RX_KEY_BIT];
	assign standalone_key = st_reg.standalone_key;
	assign transmit_key   = st_reg.tx_key;
	assign receive_key    = st_reg.rx_key;
	assign tx_plan        = st_reg.tx_plan;
	assign rx_plan        = st_reg.rx_plan;

endmodule

// [mscr_regs_asserts.sv]
`timescale 1ns/10ps
// ==========================================================
// Port-level checks beside the register block
module mscr_regs_asserts
(
	input wire logic                     aclk,
	input wire logic                     aresetn,
	input wire logic                     s_axi_awvalid,
	input wire logic                     s_axi_awready,
	input wire logic                     s_axi_wvalid,
	input wire logic                     s_axi_wready,
	input wire logic                     s_axi_bvalid,
	input wire logic                     s_axi_arvalid,
	input wire logic                     s_axi_arready,
	input wire logic                     s_axi_rvalid,
	input wire logic [31:0]              s_axi_rdata,
	input wire logic [127:0]             first_key,
	input wire logic [127:0]             second_key,
	input wire mscr_pkg::mscr_rx_frame_s rx_frame,
	input wire logic                     fifo_init,
	input wire logic                     rx_fsm_init,
	input wire logic                     standalone_key_select,
	input wire logic [127:0]             standalone_key,
	input wire mscr_pkg::mscr_aes_plan_s tx_plan,
	input wire logic                     rx_irq,
	input wire logic                     rx_drop
);
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);

	// ==========================================================
	// Init pulses last exactly four cycles
	a_fifo_init_width: assert property ($rose(fifo_init) |->
		fifo_init[*4] ##1 !fifo_init) else $error("fifo init width");
	a_rx_init_width: assert property ($rose(rx_fsm_init) |->
		rx_fsm_init[*4] ##1 !rx_fsm_init) else $error("rx init width");

	// ==========================================================
	// Each frame outside receive init gives exactly one of the two pulses
	a_frame_one_pulse: assert property (rx_frame.done && !rx_fsm_init
		|=> rx_irq != rx_drop) else $error("frame answer");
	a_pulse_has_cause: assert property ((rx_irq || rx_drop) |->
		$past(rx_frame.done)) else $error("pulse without frame");

	// ==========================================================
	// Bus answers; only the low byte carries data
	a_write_answer: assert property (s_axi_awvalid && s_axi_awready
		&& s_axi_wvalid && s_axi_wready |=> ##1 s_axi_bvalid)
		else $error("write answer late");
	a_read_answer: assert property (s_axi_arvalid && s_axi_arready
		|=> s_axi_rvalid && !s_axi_arready) else $error("read answer");
	a_rdata_upper_zero: assert property (s_axi_rvalid |->
		s_axi_rdata[31:8] == 24'h000000) else $error("rdata upper");

	// ==========================================================
	// Key routing lags the select by one cycle
	a_sa_key_pick: assert property ($past(aresetn) |-> standalone_key ==
		($past(standalone_key_select) ? $past(second_key) : $past(first_key)))
		else $error("standalone key");
	a_tag_even: assert property (tx_plan.tag_bytes[0] == 1'b0 &&
		tx_plan.tag_bytes <= 5'h10) else $error("tag length");

	c_irq: cover property (rx_irq);
	c_drop: cover property (rx_drop);
	c_fifo_init: cover property ($rose(fifo_init));
endmodule

bind mscr_regs mscr_regs_asserts i_mscr_regs_asserts (.aclk, .aresetn,
	.s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready,
	.s_axi_bvalid, .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid,
	.s_axi_rdata, .first_key, .second_key, .rx_frame, .fifo_init,
	.rx_fsm_init, .standalone_key_select, .standalone_key, .tx_plan,
	.rx_irq, .rx_drop);

// [mscr_rx_filter.sv]
`timescale 1ns/10ps
// Gates the receive interrupt by the enabled frame filters
module mscr_rx_filter
(
	input  wire logic                     aclk,
	input  wire logic                     aresetn,
	input  wire logic                     hold,
	input  wire mscr_pkg::mscr_rx_frame_s frame,
	input  wire logic                     ack_sequence_filter,
	input  wire logic                     addr_filter,
	input  wire logic                     crc_filter,
	input  wire logic [7:0]               expected_sequence_number,
	output logic                          rx_irq,
	output logic                          rx_drop
);

	mscr_pkg::mscr_filter_state_s st_reg;
	mscr_pkg::mscr_filter_state_s st_next;
	logic                         reject;

	// ==========================================================
	// Any enabled check that fails swallows the interrupt
	always_comb
	begin
		reject = 1'b0;
		if (ack_sequence_filter && frame.is_ack &&
			frame.dsn != expected_sequence_number)
			reject = 1'b1;
		if (addr_filter && !frame.addr_match)
			reject = 1'b1;
		if (crc_filter && !frame.crc_ok)
			reject = 1'b1;
		st_next.irq  = frame.done && !hold && !reject;
		st_next.drop = frame.done && !hold && reject;
	end

	// Receive machine in init drops the frame silently
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			st_reg <= '0;
		else
			st_reg <= st_next;
	end

	assign rx_irq  = st_reg.irq;
	assign rx_drop = st_reg.drop;

endmodule

// [test_mac_security_control_regs.sv]
`timescale 1ns/10ps
module test_mac_security_control_regs;
	logic                     aclk, aresetn;
	logic [15:0]              s_axi_awaddr, s_axi_araddr;
	logic                     s_axi_awvalid, s_axi_wvalid, s_axi_bready;
	logic                     s_axi_arvalid, s_axi_rready;
	logic                     s_axi_awready, s_axi_wready, s_axi_bvalid;
	logic                     s_axi_arready, s_axi_rvalid;
	logic [31:0]              s_axi_wdata, s_axi_rdata;
	logic [3:0]               s_axi_wstrb;
	logic [1:0]               s_axi_bresp, s_axi_rresp;
	logic [127:0]             first_key, second_key;
	logic [127:0]             standalone_key, transmit_key, receive_key;
	mscr_pkg::mscr_rx_frame_s rx_frame;
	mscr_pkg::mscr_aes_plan_s tx_plan, rx_plan;
	logic                     fifo_init, tx_fsm_init, rx_fsm_init, aes_init;
	logic                     coordinator_role, bank_select, rx_irq, rx_drop;
	logic                     standalone_key_select, transmit_key_select;
	logic                     receive_key_select;
	logic [3:0]               init, seen;
	logic [15:0]              idx [5];
	logic [7:0]               ev [5];
	logic [4:0]               tag;
	logic [1:0]               m;
	int                       err_count, check_count, n;

	assign init = {fifo_init, tx_fsm_init, rx_fsm_init, aes_init};

	mscr_regs i_mscr_regs (.*);

	// Free-running 100 MHz clock
	initial
	begin
		aclk = 1'b0;
		forever #5 aclk = ~aclk;
	end

	// ==========================================================
	// Compare and report
	task automatic check(input logic [31:0] s, input logic [31:0] e);
		check_count++;
		if (s !== e)
		begin
			err_count++;
			$display("unexpected at %0t: seen %h expected %h", $time, s, e);
		end
	endtask

	task automatic report_and_stop;
		$display("errors %0d checks %0d", err_count, check_count);
		if (err_count == 0 && check_count > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask

	// ==========================================================
	// Bus master; one edge first so ready strobes never double-assign
	task automatic wr(input logic [15:0] a, input logic [7:0] d,
		input logic [1:0] er);
		@(posedge aclk);
		s_axi_awaddr <= {a[13:0], 2'b00};
		s_axi_wdata <= {24'h000000, d};
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		forever
		begin
			@(posedge aclk);
			if (s_axi_awready) s_axi_awvalid <= 1'b0;
			if (s_axi_wready) s_axi_wvalid <= 1'b0;
			if (s_axi_bvalid) break;
		end
		s_axi_bready <= 1'b0;
		check(32'(s_axi_bresp), 32'(er));
	endtask

	task automatic rd(input logic [15:0] a, input logic [7:0] e,
		input logic [1:0] er);
		@(posedge aclk);
		s_axi_araddr <= {a[13:0], 2'b00};
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		forever
		begin
			@(posedge aclk);
			if (s_axi_arready) s_axi_arvalid <= 1'b0;
			if (s_axi_rvalid) break;
		end
		s_axi_rready <= 1'b0;
		check(s_axi_rdata, {24'h000000, e});
		check(32'(s_axi_rresp), 32'(er));
	endtask

	// One frame summary, then the answer one cycle after it is taken
	task automatic fr(input logic a, input logic [7:0] d, input logic am,
		input logic cr, input logic ei);
		@(posedge aclk);
		rx_frame <= {1'b1, a, d, am, cr};
		@(posedge aclk);
		rx_frame.done <= 1'b0;
		@(posedge aclk);
		check(32'({rx_irq, rx_drop}), 32'({ei, !ei}));
	endtask

	// ==========================================================
	// Main sequence
	initial
	begin
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 3'h0;
		{s_axi_arvalid, s_axi_rready, aresetn} = 3'h0;
		{s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 64'h0;
		s_axi_wstrb = 4'hF;
		rx_frame = '0;
		first_key = {4{32'h01234567}};
		second_key = {4{32'h89ABCDEF}};
		err_count = 0;
		check_count = 0;
		repeat (6) @(posedge aclk);
		aresetn <= 1'b1;
		idx = '{mscr_pkg::IDX_MACCTL, mscr_pkg::IDX_SEQ, mscr_pkg::IDX_TXLEN,
			mscr_pkg::IDX_RXLEN, mscr_pkg::IDX_MAP};
		ev = '{8'h1E, 8'hFF, 8'h7F, 8'h7F, 8'h01};
		rd(mscr_pkg::IDX_RESET, 8'h00, 2'h0);
		rd(mscr_pkg::IDX_SECCTL, 8'h00, 2'h0);
		// Reset values, then reserved bits dropped on write
		for (int i = 0; i < 5; i++)
		begin
			rd(idx[i], 8'h00, 2'h0);
			wr(idx[i], 8'hFF, 2'h0);
			rd(idx[i], ev[i], 2'h0);
		end
		check(32'(coordinator_role), 32'h1);
		check(32'(bank_select), 32'h1);
		wr(16'h2196, 8'hFF, 2'h2);
		rd(16'h2196, 8'h00, 2'h2);
		// Key routing per path
		wr(mscr_pkg::IDX_SECCTL, 8'hA0, 2'h0);
		rd(mscr_pkg::IDX_SECCTL, 8'hA0, 2'h0);
		check(standalone_key[127:96], second_key[127:96]);
		check(transmit_key[31:0], first_key[31:0]);
		check(receive_key[127:96], second_key[127:96]);
		check(32'({standalone_key_select, transmit_key_select,
			receive_key_select}), 32'h5);
		// Every tag code, with the mode taken from its low two bits
		wr(mscr_pkg::IDX_TXLEN, 8'h2A, 2'h0);
		wr(mscr_pkg::IDX_RXLEN, 8'h15, 2'h0);
		for (int i = 0; i < 8; i++)
		begin
			m = i[1:0];
			tag = m[0] ? ((i == 7) ? 5'h10 : 5'(4 + 2 * i)) : 5'h00;
			wr(mscr_pkg::IDX_SECCTL, {3'h0, i[2:0], m}, 2'h0);
			repeat (2) @(posedge aclk);
			check(32'(tx_plan.cipher_en), 32'(m[1]));
			check(32'(tx_plan.auth_en), 32'(m[0]));
			check(32'(tx_plan.tag_bytes), 32'(tag));
			if (m[1])
				check(32'(rx_plan.cipher_offset), 32'h15);
			if (m == mscr_pkg::MODE_CBC)
				check(32'(tx_plan.auth_offset), 32'h2A);
			if (m == mscr_pkg::MODE_CCM)
				check(32'(tx_plan.auth_only_len), 32'h2A);
		end
		// Each reset bit: one unit, four cycles, then self-clear
		for (int b = 0; b < 4; b++)
		begin
			wr(mscr_pkg::IDX_RESET, (8'h80 >> b) | 8'h0F, 2'h0);
			n = 0;
			seen = 4'h0;
			repeat (8)
			begin
				@(posedge aclk);
				n += $countones(init);
				seen |= init;
			end
			check(32'(n), 32'h4);
			check(32'(seen), 32'h8 >> b);
			rd(mscr_pkg::IDX_RESET, 8'h00, 2'h0);
		end
		// Receive interrupt filtering
		wr(mscr_pkg::IDX_SEQ, 8'h33, 2'h0);
		// Lane 0 off: write answered but ignored
		s_axi_wstrb <= 4'hE;
		wr(mscr_pkg::IDX_SEQ, 8'h55, 2'h0);
		s_axi_wstrb <= 4'hF;
		rd(mscr_pkg::IDX_SEQ, 8'h33, 2'h0);
		fr(1'b1, 8'h33, 1'b1, 1'b1, 1'b1);
		fr(1'b1, 8'h34, 1'b1, 1'b1, 1'b0);
		fr(1'b0, 8'h34, 1'b1, 1'b1, 1'b1);
		fr(1'b1, 8'h33, 1'b0, 1'b1, 1'b0);
		fr(1'b1, 8'h33, 1'b1, 1'b0, 1'b0);
		wr(mscr_pkg::IDX_MACCTL, 8'h00, 2'h0);
		fr(1'b1, 8'h34, 1'b0, 1'b0, 1'b1);
		check(32'(coordinator_role), 32'h0);
		report_and_stop();
	end

	// Hang guard, far beyond the few hundred cycles the tests need
	initial
	begin
		repeat (20000) @(posedge aclk);
		err_count++;
		report_and_stop();
	end
endmodule
